/* verilog/mmd_decoder.sv */
// memory map decoder with boot remap for flash, sram and peripheral registers
`timescale 1ns/1ns
`default_nettype none
`include "mmd_defs.svh"

// Summary of operation
// - after reset flash answers at address zero
// - remap bit0 cleared puts sram at zero
// - one linear 32-bit byte address space
// - multi-byte data stored little endian
// - flash 32k halfwords, top 1k boot loader
// - flash organised in 256-byte pages
// - 32-bit flash access becomes two halfword accesses
// - flash full words run at half rate
// - sram 2k words, one access per word
// - register space sits in top address pages
// - register accesses routed to addressed peripheral
// - remap register at 0x0220, one byte, only bit0 RW, other bits read zero
module mmd_decoder
  import mmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_req,
  input wire mmd_req_s cpu_cmd,
  output logic cpu_ack_q,
  output logic [31:0] cpu_rdata_q,
  output logic flash_req_q,
  output logic flash_we_q,
  output logic [14:0] flash_addr_q,
  output logic [15:0] flash_wdata_q,
  output logic [1:0] flash_be_q,
  output logic [7:0] flash_page_q,
  output logic flash_boot_q,
  input wire logic flash_ack,
  input wire logic [15:0] flash_rdata,
  output logic sram_req_q,
  output logic sram_we_q,
  output logic [10:0] sram_addr_q,
  output logic [31:0] sram_wdata_q,
  output logic [3:0] sram_be_q,
  input wire logic sram_ack,
  input wire logic [31:0] sram_rdata,
  output logic periph_req_q,
  output logic periph_we_q,
  output logic [7:0] periph_blk_q,
  output logic [7:0] periph_ofs_q,
  output logic [31:0] periph_wdata_q,
  output logic [3:0] periph_be_q,
  input wire logic periph_ack,
  input wire logic [31:0] periph_rdata,
  output logic flash_at_zero_q
);

  function automatic logic grp_mapped(input logic [7:0] g);
    case (g)
      8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07: grp_mapped = 1'b1;
      8'h08, 8'h09, 8'h0A, 8'h0B, 8'hF0, 8'hF4, 8'hF8: grp_mapped = 1'b1;
      default: grp_mapped = 1'b0;
    endcase
  endfunction : grp_mapped

  mmd_state_e st_q;
  logic [7:0] remap_q;
  logic fl_done;
  logic [31:0] fl_rdata;

  wire [31:0] a = cpu_cmd.addr;
  wire take = st_q == ST_IDLE && cpu_req;
  wire in_zero_fl = a < `MMD_FLASH_SIZE;
  wire in_zero_sr = a < `MMD_SRAM_SIZE;
  wire zero_flash = remap_q[`MMD_REMAP_FLASH_BIT] && in_zero_fl;
  wire zero_sram = !remap_q[`MMD_REMAP_FLASH_BIT] && in_zero_sr;
  wire in_flash = a >= `MMD_FLASH_BASE && a < (`MMD_FLASH_BASE + `MMD_FLASH_SIZE);
  wire in_sram = a >= `MMD_SRAM_BASE && a < (`MMD_SRAM_BASE + `MMD_SRAM_SIZE);
  // full 32-bit compare, no partial decode aliases
  wire hit_flash = zero_flash || in_flash;
  wire hit_sram = zero_sram || in_sram;
  wire hit_mmr = a[31:16] == `MMD_MMR_TOP;
  wire hit_remap = hit_mmr && a[15:2] == `MMD_REMAP_OFS >> 2;
  wire hit_periph = hit_mmr && !hit_remap && grp_mapped(a[15:8]);
  wire remap_wr = take && hit_remap && cpu_cmd.we && cpu_cmd.be[0];
  wire [31:0] remap_rd = {24'h00_0000, remap_q};
  // local answer: remap register or nothing mapped
  wire [31:0] local_rd = (hit_remap && !cpu_cmd.we) ? remap_rd : 32'h0000_0000;
  wire fl_start = take && hit_flash;

  mmd_flash_narrow u_flash (
    .clk(clk),
    .rst_n(rst_n),
    .start(fl_start),
    .byte_ofs(a[15:0]),
    .be(cpu_cmd.be),
    .we(cpu_cmd.we),
    .wdata(cpu_cmd.wdata),
    .done_q(fl_done),
    .rdata_q(fl_rdata),
    .flash_req_q(flash_req_q),
    .flash_we_q(flash_we_q),
    .flash_addr_q(flash_addr_q),
    .flash_wdata_q(flash_wdata_q),
    .flash_be_q(flash_be_q),
    .flash_page_q(flash_page_q),
    .flash_boot_q(flash_boot_q),
    .flash_ack(flash_ack),
    .flash_rdata(flash_rdata)
  );

  // remap register; only the flash select bit is stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remap_q <= `MMD_REMAP_RST;
      flash_at_zero_q <= 1'b1;
    end else begin
      if (remap_wr) begin
        remap_q <= {7'h00, cpu_cmd.wdata[`MMD_REMAP_FLASH_BIT]};
        flash_at_zero_q <= cpu_cmd.wdata[`MMD_REMAP_FLASH_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cpu_ack_q <= 1'b0;
      cpu_rdata_q <= 32'h0000_0000;
      sram_req_q <= 1'b0;
      sram_we_q <= 1'b0;
      sram_addr_q <= 11'h000;
      sram_wdata_q <= 32'h0000_0000;
      sram_be_q <= 4'h0;
      periph_req_q <= 1'b0;
      periph_we_q <= 1'b0;
      periph_blk_q <= 8'h00;
      periph_ofs_q <= 8'h00;
      periph_wdata_q <= 32'h0000_0000;
      periph_be_q <= 4'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (take) begin
            if (hit_flash) begin
              st_q <= ST_FLASH;
            end else if (hit_sram) begin
              // 32-bit wide, whole word in one access
              sram_req_q <= 1'b1;
              sram_we_q <= cpu_cmd.we;
              sram_addr_q <= a[12:2];
              sram_wdata_q <= cpu_cmd.wdata;
              sram_be_q <= cpu_cmd.be;
              st_q <= ST_SRAM;
            end else if (hit_periph) begin
              periph_req_q <= 1'b1;
              periph_we_q <= cpu_cmd.we;
              periph_blk_q <= a[15:8];
              periph_ofs_q <= a[7:0];
              periph_wdata_q <= cpu_cmd.wdata;
              periph_be_q <= cpu_cmd.be;
              st_q <= ST_PERIPH;
            end else begin
              cpu_rdata_q <= local_rd;
              cpu_ack_q <= 1'b1;
              st_q <= ST_DONE;
            end
          end
        end
        ST_FLASH: begin
          if (fl_done) begin
            cpu_rdata_q <= fl_rdata;
            cpu_ack_q <= 1'b1;
            st_q <= ST_DONE;
          end
        end
        ST_SRAM: begin
          if (sram_ack) begin
            sram_req_q <= 1'b0;
            cpu_rdata_q <= sram_rdata;
            cpu_ack_q <= 1'b1;
            st_q <= ST_DONE;
          end
        end
        ST_PERIPH: begin
          if (periph_ack) begin
            periph_req_q <= 1'b0;
            cpu_rdata_q <= periph_rdata;
            cpu_ack_q <= 1'b1;
            st_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          cpu_ack_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  AST_ZERO_IS_FLASH: assert property (@(posedge clk) disable iff (!rst_n)
    take && a < 32'h0001_0000 && remap_q[0] |=> st_q == ST_FLASH && (flash_req_q || fl_done))
    else $error("address zero did not reach flash while remap bit set");

  AST_ZERO_IS_SRAM: assert property (@(posedge clk) disable iff (!rst_n)
    take && a < 32'h0000_2000 && !remap_q[0] |=> sram_req_q && sram_addr_q == $past(a[12:2]))
    else $error("address zero did not reach sram after remap");

  AST_REMAP_ONLY_BY_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(remap_q[0]) |-> $past(remap_wr) && !$past(cpu_cmd.wdata[0]))
    else $error("remap bit cleared without a register write");

  AST_REMAP_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    take && a == 32'hFFFF_0220 && cpu_cmd.we && cpu_cmd.be[0]
      |=> remap_q == {7'h00, $past(cpu_cmd.wdata[0])} && cpu_ack_q)
    else $error("remap register write not taken");

  AST_SRAM_ONE_ACCESS: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_SRAM && sram_ack |=> cpu_ack_q && !sram_req_q
      && cpu_rdata_q == $past(sram_rdata))
    else $error("sram word not answered from a single access");

  AST_PERIPH_ROUTE: assert property (@(posedge clk) disable iff (!rst_n)
    take && hit_periph |=> periph_req_q && periph_blk_q == $past(a[15:8])
      && periph_ofs_q == $past(a[7:0]))
    else $error("register access not routed to its peripheral");

  AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    take && !hit_flash && !hit_sram && !hit_mmr
      |=> cpu_ack_q && cpu_rdata_q == 32'h0000_0000 && !periph_req_q && !sram_req_q)
    else $error("unmapped access did not read zero");

  AST_ACK_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_ack_q |=> !cpu_ack_q && st_q == ST_IDLE)
    else $error("answer strobe longer than one cycle");

endmodule : mmd_decoder
`default_nettype wire

/* verilog/mmd_defs.svh */
// memory map decoder constants: region bases, sizes, offsets, reset values
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

`define MMD_FLASH_BASE 32'h0008_0000
`define MMD_FLASH_SIZE 32'h0001_0000
`define MMD_SRAM_BASE 32'h0001_0000
`define MMD_SRAM_SIZE 32'h0000_2000
`define MMD_MMR_TOP 16'hFFFF
`define MMD_REMAP_OFS 16'h0220
`define MMD_REMAP_RST 8'h01
`define MMD_REMAP_FLASH_BIT 0
`define MMD_FLASH_HW_WORDS 32768
`define MMD_FLASH_BOOT_WORDS 1024
`define MMD_FLASH_BOOT_START 15'h7C00
`define MMD_PAGE_BYTES 256
`define MMD_PAGE_LSB 7
`define MMD_SRAM_WORDS 2048

`endif

/* verilog/mmd_pkg.sv */
// memory map decoder types
package mmd_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic we;
  } mmd_req_s;

  typedef enum logic [2:0] {ST_IDLE, ST_FLASH, ST_SRAM, ST_PERIPH, ST_DONE} mmd_state_e;

  typedef enum logic [1:0] {FL_IDLE, FL_LO, FL_HI} mmd_fl_state_e;

endpackage : mmd_pkg

/* verilog/mmd_flash_narrow.sv */
// splits one 32-bit access into halfword accesses on the 16-bit flash array
`timescale 1ns/1ns
`default_nettype none
`include "mmd_defs.svh"

module mmd_flash_narrow
  import mmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [15:0] byte_ofs,
  input wire logic [3:0] be,
  input wire logic we,
  input wire logic [31:0] wdata,
  output logic done_q,
  output logic [31:0] rdata_q,
  output logic flash_req_q,
  output logic flash_we_q,
  output logic [14:0] flash_addr_q,
  output logic [15:0] flash_wdata_q,
  output logic [1:0] flash_be_q,
  output logic [7:0] flash_page_q,
  output logic flash_boot_q,
  input wire logic flash_ack,
  input wire logic [15:0] flash_rdata
);

  mmd_fl_state_e st_q;
  logic [3:0] be_q;
  logic [15:0] whi_q;
  logic [13:0] word_q;

  wire need_lo = |be[1:0];
  wire need_hi = |be[3:2];
  wire hi_pend = |be_q[3:2];
  wire [14:0] lo_addr = {byte_ofs[15:2], 1'b0};
  wire [14:0] hi_addr = {word_q, 1'b1};
  wire [14:0] start_addr = need_lo ? lo_addr : {byte_ofs[15:2], 1'b1};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= FL_IDLE;
      be_q <= 4'h0;
      whi_q <= 16'h0000;
      word_q <= 14'h0000;
      done_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      flash_req_q <= 1'b0;
      flash_we_q <= 1'b0;
      flash_addr_q <= 15'h0000;
      flash_wdata_q <= 16'h0000;
      flash_be_q <= 2'h0;
      flash_page_q <= 8'h00;
      flash_boot_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        FL_IDLE: begin
          if (start) begin
            be_q <= be;
            whi_q <= wdata[31:16];
            word_q <= byte_ofs[15:2];
            flash_we_q <= we;
            rdata_q <= 32'h0000_0000;
            if (need_lo || need_hi) begin
              // low halfword first: least significant byte at lowest address
              flash_req_q <= 1'b1;
              flash_addr_q <= start_addr;
              flash_wdata_q <= need_lo ? wdata[15:0] : wdata[31:16];
              flash_be_q <= need_lo ? be[1:0] : be[3:2];
              flash_page_q <= start_addr[14:`MMD_PAGE_LSB];
              flash_boot_q <= start_addr >= `MMD_FLASH_BOOT_START;
              st_q <= need_lo ? FL_LO : FL_HI;
            end else begin
              done_q <= 1'b1;
            end
          end
        end
        FL_LO: begin
          if (flash_ack) begin
            rdata_q[15:0] <= flash_rdata;
            if (hi_pend) begin
              // second access of a full word halves the fetch rate
              flash_addr_q <= hi_addr;
              flash_wdata_q <= whi_q;
              flash_be_q <= be_q[3:2];
              flash_page_q <= hi_addr[14:`MMD_PAGE_LSB];
              flash_boot_q <= hi_addr >= `MMD_FLASH_BOOT_START;
              st_q <= FL_HI;
            end else begin
              flash_req_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= FL_IDLE;
            end
          end
        end
        FL_HI: begin
          if (flash_ack) begin
            rdata_q[31:16] <= flash_rdata;
            flash_req_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= FL_IDLE;
          end
        end
        default: st_q <= FL_IDLE;
      endcase
    end
  end

  AST_FLASH_SECOND_HALF: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == FL_LO && flash_ack && hi_pend |=> flash_req_q && flash_addr_q[0] && st_q == FL_HI)
    else $error("full word did not issue a second flash access");

  AST_FLASH_LOW_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == FL_IDLE && start && be == 4'hF |=> flash_req_q && !flash_addr_q[0]
      && flash_be_q == 2'h3)
    else $error("full word did not start with the low halfword");

  AST_FLASH_PAGE: assert property (@(posedge clk) disable iff (!rst_n)
    flash_req_q |-> flash_page_q == flash_addr_q[14:7])
    else $error("flash page index does not match the halfword address");

  AST_FLASH_BOOT: assert property (@(posedge clk) disable iff (!rst_n)
    flash_req_q |-> flash_boot_q == (flash_addr_q >= 15'h7C00))
    else $error("boot loader area flag wrong");

endmodule : mmd_flash_narrow
`default_nettype wire

/* verif/mmd_far_model.sv */
// far side model: flash halfword array, sram word array, peripheral responder
`timescale 1ns/1ns
`default_nettype none
module mmd_far_model
  import mmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] dly,
  input wire logic flash_req,
  input wire logic flash_we,
  input wire logic [14:0] flash_addr,
  input wire logic [15:0] flash_wdata,
  input wire logic [1:0] flash_be,
  input wire logic [7:0] flash_page,
  input wire logic flash_boot,
  output logic flash_ack,
  output logic [15:0] flash_rdata,
  input wire logic sram_req,
  input wire logic sram_we,
  input wire logic [10:0] sram_addr,
  input wire logic [31:0] sram_wdata,
  input wire logic [3:0] sram_be,
  output logic sram_ack,
  output logic [31:0] sram_rdata,
  input wire logic periph_req,
  input wire logic [7:0] periph_blk,
  input wire logic [7:0] periph_ofs,
  output logic periph_ack,
  output logic [31:0] periph_rdata
);
  logic [15:0] fl_mem [0:32767];
  logic [31:0] sr_mem [0:2047];
  logic [1:0] fcnt, scnt, pcnt;
  logic [15:0] cyc;
  int n_flash, n_sram, n_periph, n_bad;
  // ack after dly wait cycles; data lines toggle when not answering
  assign flash_ack = flash_req && fcnt == dly;
  assign sram_ack = sram_req && scnt == dly;
  assign periph_ack = periph_req && pcnt == dly;
  assign flash_rdata = flash_ack ? fl_mem[flash_addr] : ~cyc;
  assign sram_rdata = sram_ack ? sr_mem[sram_addr] : {cyc, ~cyc};
  assign periph_rdata = periph_ack ? {8'h5A, periph_blk, periph_ofs, 8'hC3} : {2{cyc}};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {fcnt, scnt, pcnt, cyc} <= '0;
    end else begin
      cyc <= cyc + 16'h0001;
      fcnt <= (flash_req && !flash_ack) ? fcnt + 2'h1 : 2'h0;
      scnt <= (sram_req && !sram_ack) ? scnt + 2'h1 : 2'h0;
      pcnt <= (periph_req && !periph_ack) ? pcnt + 2'h1 : 2'h0;
      if (periph_ack) n_periph <= n_periph + 1;
      if (flash_ack) begin
        n_flash <= n_flash + 1;
        // page and boot flags must track the halfword index
        if (flash_page !== flash_addr[14:7] || flash_boot !== (flash_addr >= 15'h7C00)) begin
          n_bad <= n_bad + 1;
        end
        for (int i = 0; i < 2; i++) if (flash_we && flash_be[i]) fl_mem[flash_addr][i*8+:8] <= flash_wdata[i*8+:8];
      end
      if (sram_ack) begin
        n_sram <= n_sram + 1;
        for (int i = 0; i < 4; i++) if (sram_we && sram_be[i]) sr_mem[sram_addr][i*8+:8] <= sram_wdata[i*8+:8];
      end
    end
  end
endmodule : mmd_far_model
`default_nettype wire

/* verif/tb_top.sv */
// testbench for the memory map decoder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mmd_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cpu_req = 1'b0;
  mmd_req_s cpu_cmd = '0;
  logic [1:0] dly = 2'h0;
  logic cpu_ack_q, flash_req_q, flash_we_q, flash_boot_q, flash_ack, sram_req_q, sram_we_q;
  logic periph_req_q, periph_ack, sram_ack, flash_at_zero_q, periph_we_q;
  logic [31:0] cpu_rdata_q, sram_wdata_q, sram_rdata, periph_rdata, periph_wdata_q;
  logic [14:0] flash_addr_q;
  logic [15:0] flash_wdata_q, flash_rdata;
  logic [1:0] flash_be_q;
  logic [7:0] flash_page_q, periph_blk_q, periph_ofs_q, b;
  logic [10:0] sram_addr_q;
  logic [3:0] sram_be_q, periph_be_q;
  logic [7:0] grp_ok [6] = '{8'h00, 8'h03, 8'h0B, 8'hF0, 8'hF4, 8'hF8};
  logic [7:0] grp_bad [3] = '{8'h0C, 8'h80, 8'hFF};
  logic [31:0] seed = 32'd44725, a, d;
  logic [32:0] exp_q [$];
  int mismatches = 0, tests_run = 0, cycles = 0, n0;
  mmd_decoder dut_u (.clk, .rst_n, .cpu_req, .cpu_cmd, .cpu_ack_q, .cpu_rdata_q, .flash_req_q,
    .flash_we_q, .flash_addr_q, .flash_wdata_q, .flash_be_q, .flash_page_q, .flash_boot_q,
    .flash_ack, .flash_rdata, .sram_req_q, .sram_we_q, .sram_addr_q, .sram_wdata_q, .sram_be_q,
    .sram_ack, .sram_rdata, .periph_req_q, .periph_we_q, .periph_blk_q, .periph_ofs_q,
    .periph_wdata_q, .periph_be_q, .periph_ack, .periph_rdata, .flash_at_zero_q);
  mmd_far_model far_u (.clk, .rst_n, .dly, .flash_req(flash_req_q), .flash_we(flash_we_q),
    .flash_addr(flash_addr_q), .flash_wdata(flash_wdata_q), .flash_be(flash_be_q),
    .flash_page(flash_page_q), .flash_boot(flash_boot_q), .flash_ack, .flash_rdata,
    .sram_req(sram_req_q), .sram_we(sram_we_q), .sram_addr(sram_addr_q),
    .sram_wdata(sram_wdata_q), .sram_be(sram_be_q), .sram_ack, .sram_rdata,
    .periph_req(periph_req_q), .periph_blk(periph_blk_q), .periph_ofs(periph_ofs_q),
    .periph_ack, .periph_rdata);
  always #5 clk = ~clk;
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // one bus access; request held until the ack cycle has been seen
  task automatic access(input logic [31:0] ad, input logic [31:0] wd, input logic [3:0] be,
                        input logic we, input logic chk, input logic [31:0] e);
    int n;
    @(posedge clk);
    dly <= 2'(next_rand());
    cpu_req <= 1'b1;
    cpu_cmd <= '{addr: ad, wdata: wd, be: be, we: we};
    exp_q.push_back({chk, e});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cpu_ack_q !== 1'b1 && n < 60);
    cpu_req <= 1'b0;
    if (n >= 60) check("ack wait", 32'h0, 32'h1);
  endtask : access
  task automatic wr(input logic [31:0] ad, input logic [31:0] wd, input logic [3:0] be);
    access(ad, wd, be, 1'b1, 1'b0, 32'h0);
  endtask : wr
  task automatic rd(input logic [31:0] ad, input logic [31:0] e);
    access(ad, 32'h0, 4'hF, 1'b0, 1'b1, e);
  endtask : rd
  // answer watcher: oldest expectation against each ack
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end else if (cpu_ack_q === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected ack", 32'h0, 32'h1);
      else if (exp_q[0][32]) check("read data", cpu_rdata_q, exp_q[0][31:0]);
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("flash at zero", {31'h0, flash_at_zero_q}, 32'h1);
    rd(32'hFFFF_0220, 32'h1);
    for (int i = 0; i < 6; i++) begin
      a = (i == 5) ? 32'h0008_FFFC : (32'h0008_0000 | (next_rand() & 32'h0000_FFFC));
      d = next_rand();
      wr(a, d, 4'hF);
      n0 = far_u.n_flash;
      rd(a, d);
      check("flash halves", far_u.n_flash - n0, 32'h2);
      check("flash low half", {16'h0, far_u.fl_mem[a[15:1]]}, {16'h0, d[15:0]});
      rd(a & 32'h0000_FFFF, d);
    end
    a = 32'h0008_0100;
    wr(a, 32'h0, 4'hF);
    wr(a, 32'h0000_00AA, 4'h1);
    wr(a, 32'hBB00_0000, 4'h8);
    n0 = far_u.n_flash;
    wr(a, 32'hFFFF_FFFF, 4'h0);
    check("empty enables", far_u.n_flash - n0, 32'h0);
    rd(a, 32'hBB00_00AA);
    for (int i = 0; i < 4; i++) begin
      a = 32'h0001_0000 | (next_rand() & 32'h0000_1FFC);
      d = next_rand();
      wr(a, d, 4'hF);
      n0 = far_u.n_sram;
      rd(a, d);
      check("sram single", far_u.n_sram - n0, 32'h1);
      check("sram word", far_u.sr_mem[a[12:2]], d);
    end
    wr(32'hFFFF_0220, 32'h0, 4'h1);
    rd(32'hFFFF_0220, 32'h0);
    check("flash at zero", {31'h0, flash_at_zero_q}, 32'h0);
    wr(32'h0001_0040, 32'h1234_5678, 4'hF);
    rd(32'h0000_0040, 32'h1234_5678);
    rd(32'h0000_3000, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("flash at zero", {31'h0, flash_at_zero_q}, 32'h1);
    wr(32'hFFFF_0220, 32'h0, 4'h2);
    rd(32'hFFFF_0220, 32'h1);
    foreach (grp_ok[i]) begin
      b = grp_ok[i];
      d = next_rand() & 32'hFC;
      n0 = far_u.n_periph;
      rd({16'hFFFF, b, d[7:0]}, {8'h5A, b, d[7:0], 8'hC3});
      check("periph routed", far_u.n_periph - n0, 32'h1);
      wr({16'hFFFF, b, d[7:0]}, ~d, 4'h3);
      check("periph we", {31'h0, periph_we_q}, 32'h1);
      check("periph be", {28'h0, periph_be_q}, 32'h3);
      check("periph wdata", periph_wdata_q, ~d);
    end
    n0 = far_u.n_periph;
    foreach (grp_bad[i]) begin
      b = grp_bad[i];
      wr({16'hFFFF, b, 8'h10}, 32'hFFFF_FFFF, 4'hF);
      rd({16'hFFFF, b, 8'h10}, 32'h0);
    end
    check("unmapped quiet", far_u.n_periph - n0, 32'h0);
    check("page and boot", far_u.n_bad, 32'h0);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
